// ---- dmis_pkg.sv ----
// Shared constants, states and carrier types for the mode indicator sequencer
package dmis_pkg;

   // ----------------------------------------------------------------
   // Clock and times in their own units
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned T_KEY_ON_S     = 1;
   localparam int unsigned T_ERASE_HOLD_S = 10;
   localparam int unsigned T_ERASE_ON_S   = 2;
   localparam int unsigned T_FLASH_S      = 15;
   localparam int unsigned T_STORE_S      = 17;
   localparam int unsigned BLINK_HALF_MS  = 250;
   localparam int unsigned BAUD_LO_BPS    = 2400;
   localparam int unsigned BAUD_HI_BPS    = 9600;

   // ----------------------------------------------------------------
   // Cycle counts derived from the clock rate
   // ----------------------------------------------------------------
   localparam int unsigned CYC_KEY_ON     = T_KEY_ON_S * CLK_HZ;
   localparam int unsigned CYC_ERASE_HOLD = T_ERASE_HOLD_S * CLK_HZ;
   localparam int unsigned CYC_ERASE_ON   = T_ERASE_ON_S * CLK_HZ;
   localparam int unsigned CYC_FLASH      = T_FLASH_S * CLK_HZ;
   localparam int unsigned CYC_STORE      = T_STORE_S * CLK_HZ;
   localparam int unsigned CYC_BLINK_HALF = BLINK_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned CYC_BIT_LO     = (CLK_HZ + BAUD_LO_BPS - 1) / BAUD_LO_BPS;
   localparam int unsigned CYC_BIT_HI     = (CLK_HZ + BAUD_HI_BPS - 1) / BAUD_HI_BPS;

   // ----------------------------------------------------------------
   // Counts and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] KEY_PRESSES   = 4'ha;
   localparam logic [3:0] PROFILE_SLOTS = 4'hf;
   localparam logic [3:0] SLOT_FIRST    = 4'h1;
   localparam logic [2:0] BLINKS_FULL   = 3'h5;
   localparam logic [2:0] BLINKS_DONE   = 3'h2;
   localparam logic [2:0] BLINKS_ONE    = 3'h1;
   localparam logic [2:0] BLINKS_DIS    = 3'h3;
   localparam logic [3:0] UART_STOP_BIT = 4'h9;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_HOLD, S_ERASE, S_LEARN, S_KEY, S_COPY_TX
   } dmis_state_t;

   typedef struct packed {
      logic learn;
      logic create_key;
      logic copy;
   } dmis_btn_t;

   typedef struct packed {
      logic key_confirm;
      logic profile_saved;
      logic erase_done;
      logic copy_profile;
      logic copy_done;
      logic copy_sent;
   } dmis_evt_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] lines;
   } dmis_byte_t;

endpackage

// ---- dmis_uart.sv ----
// Asynchronous serial export transmitter and profile import receiver
`timescale 1ns/1ps
`default_nettype none
module dmis_uart
   import dmis_pkg::*;
#(
   parameter int unsigned BIT_LO_CYC = CYC_BIT_LO,
   parameter int unsigned BIT_HI_CYC = CYC_BIT_HI
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       rate_sel,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            txd,
   input  wire logic       rxd,
   output logic            rx_valid,
   output logic [7:0]      rx_data
);
   logic [15:0] bit_cyc;
   logic [8:0]  tx_sh_reg;
   logic [3:0]  tx_bit_reg;
   logic [15:0] tx_cnt_reg;
   logic        tx_busy_reg;
   logic        rx_busy_reg;
   logic [15:0] rx_cnt_reg;
   logic [3:0]  rx_bit_reg;
   logic [7:0]  rx_sh_reg;

   // Bit period: low rate-select gives the slow default rate
   assign bit_cyc = rate_sel ? 16'(BIT_HI_CYC) : 16'(BIT_LO_CYC);

   // Transmitter: start bit, eight data bits LSB first, one stop bit
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_sh_reg   <= '1;
         tx_bit_reg  <= '0;
         tx_cnt_reg  <= '0;
         tx_busy_reg <= 1'b0;
         tx_ready    <= 1'b1;
         txd         <= 1'b1;
      end else if (clk_en) begin
         if (!tx_busy_reg) begin
            if (tx_valid) begin
               tx_sh_reg   <= {1'b1, tx_data};
               tx_busy_reg <= 1'b1;
               tx_ready    <= 1'b0;
               tx_cnt_reg  <= '0;
               tx_bit_reg  <= '0;
               txd         <= 1'b0;
            end
         end else if (tx_cnt_reg == bit_cyc - 16'h1) begin
            tx_cnt_reg <= '0;
            if (tx_bit_reg == UART_STOP_BIT) begin
               tx_busy_reg <= 1'b0;
               tx_ready    <= 1'b1;
               txd         <= 1'b1;
            end else begin
               txd        <= tx_sh_reg[0];
               tx_sh_reg  <= {1'b1, tx_sh_reg[8:1]};
               tx_bit_reg <= tx_bit_reg + 4'h1;
            end
         end else begin
            tx_cnt_reg <= tx_cnt_reg + 16'h1;
         end
      end
   end

   // Receiver: samples mid-bit; a start bit that does not hold is dropped
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_busy_reg <= 1'b0;
         rx_cnt_reg  <= '0;
         rx_bit_reg  <= '0;
         rx_sh_reg   <= '0;
         rx_valid    <= 1'b0;
         rx_data     <= '0;
      end else if (clk_en) begin
         if (!rx_busy_reg) begin
            rx_valid <= 1'b0;
            if (!rxd) begin
               rx_busy_reg <= 1'b1;
               rx_cnt_reg  <= {1'b0, bit_cyc[15:1]};
               rx_bit_reg  <= '0;
            end
         end else if (rx_cnt_reg == 16'h0) begin
            rx_cnt_reg <= bit_cyc - 16'h1;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0) begin
               rx_busy_reg <= ~rxd;
            end else if (rx_bit_reg == UART_STOP_BIT) begin
               rx_busy_reg <= 1'b0;
               rx_valid    <= rxd; // Framing error drops the byte
               rx_data     <= rx_sh_reg;
            end else begin
               rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
            end
         end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dmis_sequencer.sv ----
// Mode sequencer, status indicator and decoded outputs of the decoder
// ------------------------------------------------------------------
// Overview of operation
// - Indicator on during key generation, off after
// - Indicator on one second after key saved
// - Fifteenth profile saved: blink five times
// - Profile after fifteenth overwrites first slot
// - Indicator on while programming input high
// - Learn mode flashes until timeout or press
// - Ten second hold enters erase, indicator off
// - Erase complete: indicator on two seconds
// - Blink per copied profile, twice when done
// - Copy sending disabled: blink three times
// - Rate-select low gives 2400 bit/s serial
// - Buttons active high, externally pulled low
// - Peer profile data arrives as async serial
// - Serial export carries key and transmitter identity
// - Decoded outputs follow authorised encoder lines
// - Ten key presses, then indicator off, send
// - Store permissions on press or seventeen seconds
// - Press and release within ten seconds: learn
// - Key input high at press: key mode
// - Indicator steady on while sending copy
// - Copy and key high at power-on disable copying
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dmis_sequencer
   import dmis_pkg::*;
#(
   parameter int unsigned KEY_ON_CYC     = CYC_KEY_ON,
   parameter int unsigned ERASE_HOLD_CYC = CYC_ERASE_HOLD,
   parameter int unsigned ERASE_ON_CYC   = CYC_ERASE_ON,
   parameter int unsigned FLASH_CYC      = CYC_FLASH,
   parameter int unsigned STORE_CYC      = CYC_STORE,
   parameter int unsigned BLINK_HALF_CYC = CYC_BLINK_HALF,
   parameter int unsigned BIT_LO_CYC     = CYC_BIT_LO,
   parameter int unsigned BIT_HI_CYC     = CYC_BIT_HI
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire dmis_btn_t  btn,
   input  wire logic       rate_sel,
   input  wire dmis_evt_t  evt,
   input  wire dmis_byte_t auth,
   input  wire dmis_byte_t tx_req,
   input  wire logic       profile_import,
   output logic            status_indicator,
   output logic [7:0]      decoded_output,
   output logic            serial_export,
   output logic            tx_ready,
   output dmis_byte_t      import_byte,
   output logic            erase_req,
   output logic            perm_store,
   output logic            key_send,
   output logic            copy_send_req,
   output logic            copy_disabled,
   output logic [3:0]      write_slot
);
   // Two half-periods per blink
   function automatic logic [3:0] blink_halves(input logic [2:0] n);
      return {n, 1'b0};
   endfunction

   dmis_state_t state_reg;
   logic [31:0] tmr_reg;
   logic [3:0]  press_cnt_reg;
   logic        learn_q_reg;
   logic        key_q_reg;
   logic        por_done_reg;
   logic        erase_seen_reg;
   logic [3:0]  slot_reg;
   logic [31:0] timed_cnt_reg;
   logic [3:0]  blink_left_reg;
   logic [31:0] ph_cnt_reg;
   logic        flash_ph_reg;
   logic        ind_reg;
   logic [7:0]  decoded_reg;
   logic        erase_req_reg;
   logic        perm_store_reg;
   logic        key_send_reg;
   logic        copy_send_reg;
   logic        copy_dis_reg;
   logic        learn_rise;
   logic        key_rise;
   logic        disable_evt;
   logic        erase_show;
   logic        slot_full;
   logic        tick;
   logic        base_level;
   logic        ind_next;

   // ------------------------------------------------------------------
   // Button edges and power-on strap check
   // ------------------------------------------------------------------
   // Buttons are active high with no internal pull; taken as synchronous
   assign learn_rise  = btn.learn & ~learn_q_reg;
   assign key_rise    = btn.create_key & ~key_q_reg;
   // Only the first enabled cycle after reset counts as power-on
   assign disable_evt = ~por_done_reg & btn.copy & btn.create_key;
   assign erase_show  = (state_reg == S_ERASE) & (erase_seen_reg | evt.erase_done)
                        & ~btn.learn;
   assign slot_full   = evt.profile_saved & (slot_reg == PROFILE_SLOTS);
   assign tick        = (ph_cnt_reg == 32'(BLINK_HALF_CYC - 1));

   // Edge history; reset value high avoids a false press at start-up
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         learn_q_reg  <= 1'b1;
         key_q_reg    <= 1'b1;
         por_done_reg <= 1'b0;
      end else if (clk_en) begin
         learn_q_reg  <= btn.learn;
         key_q_reg    <= btn.create_key;
         por_done_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Mode state machine
   // ------------------------------------------------------------------
   // One shared timer restarts on every mode entry except S_ERASE, where it keeps counting
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg      <= S_IDLE;
         tmr_reg        <= '0;
         press_cnt_reg  <= '0;
         erase_seen_reg <= 1'b0;
         erase_req_reg  <= 1'b0;
         perm_store_reg <= 1'b0;
         key_send_reg   <= 1'b0;
         copy_send_reg  <= 1'b0;
      end else if (clk_en) begin
         erase_req_reg  <= 1'b0;
         perm_store_reg <= 1'b0;
         key_send_reg   <= 1'b0;
         copy_send_reg  <= 1'b0;
         tmr_reg        <= tmr_reg + 32'h1;
         case (state_reg)
            S_IDLE: begin
               tmr_reg <= '0;
               if (learn_rise) begin
                  if (btn.create_key) begin
                     state_reg     <= S_KEY;
                     press_cnt_reg <= '0;
                  end else if (btn.copy && !copy_dis_reg) begin
                     state_reg     <= S_COPY_TX;
                     copy_send_reg <= 1'b1;
                  end else begin
                     state_reg <= S_HOLD;
                  end
               end
            end
            S_HOLD: begin
               if (!btn.learn) begin
                  state_reg <= S_LEARN;
                  tmr_reg   <= '0;
               end else if (tmr_reg == 32'(ERASE_HOLD_CYC - 1)) begin
                  state_reg      <= S_ERASE;
                  erase_req_reg  <= 1'b1;
                  erase_seen_reg <= 1'b0;
               end
            end
            S_ERASE: begin
               // Done may come while the button is still held
               if (evt.erase_done) begin
                  erase_seen_reg <= 1'b1;
               end
               if (erase_show) begin
                  state_reg <= S_IDLE;
               end
            end
            S_LEARN: begin
               if (learn_rise || tmr_reg == 32'(STORE_CYC - 1)) begin
                  state_reg      <= S_IDLE;
                  perm_store_reg <= 1'b1;
               end
            end
            S_KEY: begin
               if (key_rise) begin
                  if (press_cnt_reg == KEY_PRESSES - 4'h1) begin
                     state_reg    <= S_IDLE;
                     key_send_reg <= 1'b1;
                  end else begin
                     press_cnt_reg <= press_cnt_reg + 4'h1;
                  end
               end
            end
            S_COPY_TX: begin
               if (evt.copy_sent) begin
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Profile slot pointer and copy lock
   // ------------------------------------------------------------------
   // Slot after the fifteenth wraps to the first, overwriting it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         slot_reg <= SLOT_FIRST;
      end else if (clk_en) begin
         if (erase_show) begin
            slot_reg <= SLOT_FIRST;
         end else if (evt.profile_saved) begin
            slot_reg <= slot_full ? SLOT_FIRST : slot_reg + 4'h1;
         end
      end
   end

   // Lock holds until memory is cleared; the set wins over the clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         copy_dis_reg <= 1'b0;
      end else if (clk_en) begin
         if (disable_evt) begin
            copy_dis_reg <= 1'b1;
         end else if (erase_show) begin
            copy_dis_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Indicator pattern engine
   // ------------------------------------------------------------------
   // Free-running half-period; first half of a pattern may be short
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ph_cnt_reg   <= '0;
         flash_ph_reg <= 1'b0;
      end else if (clk_en) begin
         if (tick) begin
            ph_cnt_reg   <= '0;
            flash_ph_reg <= ~flash_ph_reg;
         end else begin
            ph_cnt_reg <= ph_cnt_reg + 32'h1;
         end
      end
   end

   // Timed steady-on windows
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timed_cnt_reg <= '0;
      end else if (clk_en) begin
         if (evt.key_confirm) begin
            timed_cnt_reg <= KEY_ON_CYC;
         end else if (erase_show) begin
            timed_cnt_reg <= ERASE_ON_CYC;
         end else if (timed_cnt_reg != 32'h0) begin
            timed_cnt_reg <= timed_cnt_reg - 32'h1;
         end
      end
   end

   // Blink bursts wait behind a timed window so both stay visible
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         blink_left_reg <= '0;
      end else if (clk_en) begin
         if (slot_full) begin
            blink_left_reg <= blink_halves(BLINKS_FULL);
         end else if (evt.copy_done) begin
            blink_left_reg <= blink_halves(BLINKS_DONE);
         end else if (evt.copy_profile) begin
            blink_left_reg <= blink_halves(BLINKS_ONE);
         end else if (disable_evt) begin
            blink_left_reg <= blink_halves(BLINKS_DIS);
         end else if (timed_cnt_reg == 32'h0 && tick && blink_left_reg != 4'h0) begin
            blink_left_reg <= blink_left_reg - 4'h1;
         end
      end
   end

   // Level the current mode asks for when no overlay is active
   always_comb begin
      case (state_reg)
         S_HOLD:    base_level = 1'b1;
         S_KEY:     base_level = 1'b1;
         S_COPY_TX: base_level = 1'b1;
         S_LEARN:   base_level = flash_ph_reg & (tmr_reg < 32'(FLASH_CYC));
         default:   base_level = 1'b0;
      endcase
   end

   assign ind_next = (timed_cnt_reg != 32'h0) |
                     ((blink_left_reg != 4'h0) ? ~blink_left_reg[0] : base_level);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ind_reg <= 1'b0;
      end else if (clk_en) begin
         ind_reg <= ind_next;
      end
   end

   // ------------------------------------------------------------------
   // Decoded outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         decoded_reg <= '0;
      end else if (clk_en) begin
         decoded_reg <= auth.valid ? auth.lines : 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // Serial export and import
   // ------------------------------------------------------------------
   dmis_uart #(
      .BIT_LO_CYC (BIT_LO_CYC),
      .BIT_HI_CYC (BIT_HI_CYC)
   ) u_uart (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .rate_sel (rate_sel),
      .tx_valid (tx_req.valid),
      .tx_data  (tx_req.lines),
      .tx_ready (tx_ready),
      .txd      (serial_export),
      .rxd      (profile_import),
      .rx_valid (import_byte.valid),
      .rx_data  (import_byte.lines)
   );

   assign status_indicator = ind_reg;
   assign decoded_output   = decoded_reg;
   assign erase_req        = erase_req_reg;
   assign perm_store       = perm_store_reg;
   assign key_send         = key_send_reg;
   assign copy_send_req    = copy_send_reg;
   assign copy_disabled    = copy_dis_reg;
   assign write_slot       = slot_reg;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys iff clk_en); endclocking
   default disable iff (!rst_n);

   a_key_ind_on: assert property (
      (state_reg == S_KEY && timed_cnt_reg == 0 && blink_left_reg == 0) |=> ind_reg)
      else $error("indicator dark during key generation");
   a_key_tenth: assert property (
      key_send_reg |-> ($past(press_cnt_reg) == KEY_PRESSES - 4'h1 && state_reg == S_IDLE))
      else $error("key sent before tenth press");
   a_key_on_sec: assert property (
      evt.key_confirm |=> timed_cnt_reg == KEY_ON_CYC ##1 ind_reg)
      else $error("one second window not started");
   a_full_blink: assert property (
      slot_full |=> blink_left_reg == blink_halves(BLINKS_FULL))
      else $error("full memory blink not loaded");
   a_slot_wrap: assert property (
      (slot_full && !erase_show) |=> slot_reg == SLOT_FIRST)
      else $error("slot pointer did not wrap");
   a_hold_ind: assert property (
      (state_reg == S_HOLD && timed_cnt_reg == 0 && blink_left_reg == 0) |=> ind_reg)
      else $error("indicator dark while held");
   a_learn_exit: assert property (
      (state_reg == S_LEARN && learn_rise) |=> (state_reg == S_IDLE && perm_store_reg))
      else $error("learn mode not left on press");
   a_erase_entry: assert property (
      (state_reg == S_HOLD && btn.learn && tmr_reg == 32'(ERASE_HOLD_CYC - 1))
      |=> (state_reg == S_ERASE && erase_req_reg) ##1 !erase_req_reg)
      else $error("erase not entered after hold");
   a_erase_lit: assert property (
      (erase_show && !evt.key_confirm) |=> timed_cnt_reg == ERASE_ON_CYC)
      else $error("erase done window not started");
   a_copy_done: assert property (
      (evt.copy_done && !slot_full) |=> blink_left_reg == blink_halves(BLINKS_DONE))
      else $error("copy done blink not loaded");
   a_copy_lock: assert property (
      disable_evt |=> (copy_dis_reg && blink_left_reg != 4'h0))
      else $error("copy lock not taken");
   a_mode_pick: assert property (
      (state_reg == S_IDLE && learn_rise && btn.create_key) |=> state_reg == S_KEY)
      else $error("key mode not chosen");
   a_copy_ind: assert property (
      (state_reg == S_COPY_TX && timed_cnt_reg == 0 && blink_left_reg == 0) |=> ind_reg)
      else $error("indicator dark while sending copy");
   a_decoded: assert property (
      auth.valid |=> decoded_reg == $past(auth.lines))
      else $error("decoded outputs do not follow encoder");

   c_key_sent:   cover property (state_reg == S_KEY ##1 key_send_reg);
   c_erase:      cover property (erase_show);
   c_slot_wrap:  cover property (slot_full);
   c_learn_tout: cover property (state_reg == S_LEARN && tmr_reg == 32'(STORE_CYC - 1));
endmodule
`default_nettype wire

// ---- dmis_peer_model.sv ----
// Peer decoder model that sends one stored profile byte as serial data
`timescale 1ns/1ps
`default_nettype none
module dmis_peer_model #(
   parameter int unsigned BIT_CYC = 16
) (
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic [7:0] data,
   output logic            line
);
   logic [9:0] frame;
   int         n;
   // ----------------
   // Frame sender
   // ----------------
   // Idle high between frames; start low, LSB first, stop high
   initial begin
      line = 1'b1;
      forever begin
         @(posedge clk_sys);
         if (go) begin
            frame = {1'b1, data, 1'b0};
            for (n = 0; n < 10; n++) begin
               line <= frame[n];
               repeat (BIT_CYC) @(posedge clk_sys);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- dmis_sequencer_tb.sv ----
// Self-checking bench for the mode indicator sequencer
`timescale 1ns/1ps
`default_nettype none
module dmis_sequencer_tb;
   import dmis_pkg::*;
   logic       clk_sys, rst_n, go, pin, ind, ser, perm, ksend, cdis, got_perm, got_key;
   logic       en, rs, rdy, ereq, creq, got_erase, got_copy;
   logic [7:0] dec, imp, pd;
   localparam int unsigned K_ON = 200, E_HOLD = 1000, E_ON = 400, FL = 1500, ST = 1700;
   localparam int unsigned HALF = 20, B_LO = 16, B_HI = 8;
   logic [3:0] slot;
   logic [8:0] f;
   dmis_btn_t  btn;
   dmis_evt_t  evt;
   dmis_byte_t auth, txr, ib;
   int         num_errors, checked, i;
   logic [16:0] rows [4] = '{17'h1a5a5, 17'h0ff00, 17'h10000, 17'h18080};
   dmis_sequencer #(.KEY_ON_CYC(K_ON), .ERASE_HOLD_CYC(E_HOLD), .ERASE_ON_CYC(E_ON),
      .FLASH_CYC(FL), .STORE_CYC(ST), .BLINK_HALF_CYC(HALF), .BIT_LO_CYC(B_LO),
      .BIT_HI_CYC(B_HI)) u_dmis_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en),
      .btn(btn), .rate_sel(rs), .evt(evt), .auth(auth), .tx_req(txr),
      .profile_import(pin), .status_indicator(ind), .decoded_output(dec),
      .serial_export(ser), .tx_ready(rdy), .import_byte(ib), .erase_req(ereq),
      .perm_store(perm), .key_send(ksend), .copy_send_req(creq), .copy_disabled(cdis),
      .write_slot(slot));
   dmis_peer_model u_dmis_peer_model (.clk_sys(clk_sys), .go(go), .data(pd), .line(pin));
   // Clock, 40 ns period
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Sticky capture of one-cycle pulses
   always @(posedge clk_sys) begin
      if (perm) got_perm <= 1'b1;
      if (ksend) got_key <= 1'b1;
      if (ereq) got_erase <= 1'b1;
      if (creq) got_copy <= 1'b1;
      if (ib.valid) imp <= ib.lines;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watchdog, well past the expected run of about 4100 cycles
   initial begin
      cyc(20000);
      num_errors++;
      stop_test();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0; btn = '0; evt = '0; auth = '0; txr = '0; go = 1'b0;
      got_perm = 1'b0; got_key = 1'b0; imp = '0; num_errors = 0; checked = 0;
      en = 1'b1; rs = 1'b0; pd = 8'h3c; got_erase = 1'b0; got_copy = 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      cyc(1); #1;
      chk({7'h0, ind}, 8'h0);
      chk({4'h0, slot}, 8'h1);
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys) auth <= rows[i][16:8];
         @(posedge clk_sys) #1 chk(dec, rows[i][7:0]);
      end
      // Learn tap, then press again to store; then let the timeout store
      @(posedge clk_sys) btn <= 3'b100;
      cyc(4); #1 chk({7'h0, ind}, 8'h1);
      @(posedge clk_sys) btn <= 3'b000;
      cyc(40);
      @(posedge clk_sys) btn <= 3'b100;
      cyc(4); #1 chk({7'h0, got_perm}, 8'h1);
      @(posedge clk_sys) btn <= 3'b000;
      got_perm <= 1'b0;
      cyc(4);
      @(posedge clk_sys) btn <= 3'b100;
      cyc(4);
      @(posedge clk_sys) btn <= 3'b000;
      cyc(1600); #1 chk({7'h0, ind}, 8'h0);
      chk({7'h0, got_perm}, 8'h0);
      cyc(150); #1 chk({7'h0, got_perm}, 8'h1);
      // Key mode: key input high when programming input rises
      @(posedge clk_sys) btn <= 3'b010;
      cyc(2);
      @(posedge clk_sys) btn <= 3'b110;
      cyc(4); #1 chk({7'h0, ind}, 8'h1);
      for (i = 0; i < 10; i++) begin
         @(posedge clk_sys) btn <= 3'b000;
         cyc(2); #1 if (i == 9) chk({7'h0, got_key}, 8'h0);
         @(posedge clk_sys) btn <= 3'b010;
         cyc(2);
      end
      @(posedge clk_sys) btn <= 3'b000;
      cyc(2); #1 chk({7'h0, got_key}, 8'h1);
      chk({7'h0, ind}, 8'h0);
      // Key confirmed: indicator on for the timed window
      @(posedge clk_sys) evt <= 6'h20;
      @(posedge clk_sys) evt <= 6'h00;
      cyc(100); #1 chk({7'h0, ind}, 8'h1);
      // Enable low freezes the window, so it ends 51 cycles late
      @(posedge clk_sys) en <= 1'b0;
      cyc(50);
      @(posedge clk_sys) en <= 1'b1;
      cyc(68); #1 chk({7'h0, ind}, 8'h1);
      cyc(60); #1 chk({7'h0, ind}, 8'h0);
      // Long hold erases, release lights the window; then copy sending
      @(posedge clk_sys) btn <= 3'b100;
      cyc(1010); #1 chk({7'h0, ind}, 8'h0);
      chk({7'h0, got_erase}, 8'h1);
      @(posedge clk_sys) btn <= 3'b000;
      evt <= 6'h08;
      @(posedge clk_sys) evt <= 6'h00;
      cyc(4); #1 chk({7'h0, ind}, 8'h1);
      cyc(400);
      @(posedge clk_sys) btn <= 3'b001;
      cyc(2);
      @(posedge clk_sys) btn <= 3'b101;
      cyc(4); #1 chk({7'h0, ind}, 8'h1);
      chk({7'h0, got_copy}, 8'h1);
      @(posedge clk_sys) btn <= 3'b000;
      evt <= 6'h01;
      @(posedge clk_sys) evt <= 6'h00;
      cyc(4); #1 chk({7'h0, ind}, 8'h0);
      // Fifteen saved profiles wrap the slot pointer
      for (i = 0; i < 15; i++) begin
         @(posedge clk_sys) evt <= 6'h10;
         @(posedge clk_sys) evt <= 6'h00;
      end
      cyc(2); #1 chk({4'h0, slot}, 8'h1);
      chk({7'h0, ind}, 8'h1);
      // Serial export at the low rate, sampled mid-bit
      f = 9'h1a5;
      @(posedge clk_sys) txr <= 9'h1a5;
      @(posedge clk_sys) txr <= '0;
      cyc(8); #1 chk({7'h0, ser}, 8'h0);
      for (i = 0; i < 9; i++) begin
         cyc(16); #1 chk({7'h0, ser}, {7'h0, f[i]});
      end
      // High rate: eight cycles a bit
      cyc(30);
      @(posedge clk_sys) rs <= 1'b1;
      txr <= 9'h101;
      @(posedge clk_sys) txr <= '0;
      cyc(4); #1 chk({7'h0, ser}, 8'h0);
      chk({7'h0, rdy}, 8'h0);
      cyc(8); #1 chk({7'h0, ser}, 8'h1);
      cyc(8); #1 chk({7'h0, ser}, 8'h0);
      cyc(80);
      @(posedge clk_sys) rs <= 1'b0;
      // Profile byte from the peer decoder
      @(posedge clk_sys) go <= 1'b1;
      @(posedge clk_sys) go <= 1'b0;
      cyc(200); #1 chk(imp, 8'h3c);
      chk({7'h0, rdy}, 8'h1);
      // Second reset with copy and key high locks copy sending
      @(posedge clk_sys) rst_n <= 1'b0;
      btn <= 3'b011;
      cyc(6);
      @(posedge clk_sys) rst_n <= 1'b1;
      cyc(4); #1 chk({7'h0, cdis}, 8'h1);
      stop_test();
   end
endmodule
`default_nettype wire
